// *** design/rwc_cfg.svh ***
// constants for the reset and watchdog control block
// assumes a 125 MHz core clock and a 31 kHz low-frequency tick input
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH
`define RWC_ADDR_WDT 2'h0
`define RWC_ADDR_BOR 2'h1
`define RWC_ADDR_RCF 2'h2
`define RWC_WDT_RST 5'h0b
`define RWC_PS_MAX 5'h12
`define RWC_PS_BASE 5
`define RWC_BIT_SWE 0
`define RWC_BIT_SBE 7
`define RWC_BIT_RDY 0
`define RWC_BIT_OVF 7
`define RWC_BIT_UNF 6
`define RWC_BIT_EXT 3
`define RWC_BIT_RI 2
`define RWC_BIT_POR 1
`define RWC_BIT_BOR 0
`define RWC_MODE_OFF 2'h0
`define RWC_MODE_SW 2'h1
`define RWC_MODE_AWAKE 2'h2
`define RWC_MODE_ON 2'h3
`define RWC_POWERUP_TIMER_MS 64
`define RWC_LF_HZ 31000
`define RWC_POWERUP_TIMER_TICKS ((`RWC_POWERUP_TIMER_MS * `RWC_LF_HZ) / 1000)
`endif

// *** design/rwc_pkg.sv ***
// types for the reset and watchdog control block
// assumes nothing beyond the cfg header
package rwc_pkg;
   typedef struct packed {
      logic [1:0] watchdog_mode_cfg;
      logic [1:0] brownout_mode_cfg;
      logic powerup_timer_disable_cfg;
      logic stack_fault_reset_enable;
      logic crystal_osc;
   } rwc_cfg_t;
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rwc_bus_t;
   typedef enum logic [3:0] {
      RWC_ST_POR = 4'h1,
      RWC_ST_POWERUP_TIMER = 4'h2,
      RWC_ST_OST = 4'h4,
      RWC_ST_RUN = 4'h8
   } rwc_state_t;
endpackage

// *** design/rwc_top.sv ***
// reset sequencer, watchdog and reset-cause flags
// assumes all inputs synchronous to clk_i; lf_tick_i is a one-cycle 31 kHz tick
`timescale 1ns/1ps
`include "rwc_cfg.svh"
// What this block does
// - watchdog counts only on 31 kHz ticks
// - watchdog held cleared during oscillator start-up
// - mode 11 runs watchdog always, even asleep
// - mode 10 runs awake, stops in sleep
// - mode 00 off and cleared; 01 software
// - software enable used only in mode 01
// - entering sleep clears watchdog count
// - any reset clears watchdog prescaler
// - period code sets ratio, reserved gives 1:32
// - reset loads period 01011, clears enable
// - clear on instruction, osc fail, wake
// - oscillator divider change leaves count alone
// - brown-out mode field selects detector activity
// - software brown-out bit always read/write
// - modes 11/10 wait brown-out ready at start
// - brown-out during power-up timer restarts it
// - ready bit shows detector active and armed
// - reset instruction resets, clears its flag
// - stack faults set flag, reset if enabled
// - stack flags cleared by software or power-on
// - power-up timer then oscillator start-up timer
// - time-outs run while external pin held
// - power-up timer holds 64 ms on ticks
// - external pin reset clears its flag
// - power-on flag reads 0 after power-on
module rwc_top #(
   parameter int POWERUP_TIMER_TICKS = `RWC_POWERUP_TIMER_TICKS,
   parameter int OST_TICKS = 1024
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lf_tick_i,
   input wire rwc_pkg::rwc_cfg_t cfg_i,
   input wire rwc_pkg::rwc_bus_t bus_i,
   output logic [7:0] rdata_o,
   input wire logic por_i,
   input wire logic brownout_trip_i,
   input wire logic brownout_warm_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic sleep_i,
   input wire logic clear_watchdog_instr_i,
   input wire logic osc_fail_i,
   input wire logic wake_i,
   input wire logic reset_instr_i,
   input wire logic stack_over_i,
   input wire logic stack_under_i,
   output logic sys_reset_o,
   output logic watchdog_wake_o,
   output logic brownout_active_o
);
   import rwc_pkg::*;

   rwc_state_t state_r;
   logic [22:0] tmr_r;
   logic [22:0] wdt_r;
   logic [4:0] watchdog_period_select_r;
   logic sw_watchdog_enable_r;
   logic sw_brownout_enable_r;
   logic stack_over_flag_r, stack_under_flag_r, ext_pin_reset_flag_r, reset_instr_flag_r;
   logic por_flag_r, bor_flag_r;
   logic sleep_d_r, ost_wake_r, wdt_fire_r, soft_rst_r, ext_d_r;
   logic wdt_en, wdt_clr, bor_live, bor_event, soft_src, fault_rst, brownout_ready;
   logic [22:0] period;
   logic [22:0] wake_cnt_r;

   // prescale terminal count for a period code; reserved codes fall back to 1:32
   function automatic logic [22:0] rwc_period(input logic [4:0] sel);
      logic [4:0] s;
      s = (sel > `RWC_PS_MAX) ? 5'h00 : sel;
      return (23'h000001 << (s + 5'(`RWC_PS_BASE))) - 23'h000001;
   endfunction

   assign period = rwc_period(watchdog_period_select_r);

   always_comb begin
      unique case (cfg_i.brownout_mode_cfg)
         `RWC_MODE_ON: bor_live = 1'b1;
         `RWC_MODE_AWAKE: bor_live = ~sleep_i;
         `RWC_MODE_SW: bor_live = sw_brownout_enable_r;
         default: bor_live = 1'b0;
      endcase
   end
   assign brownout_ready = bor_live & ~brownout_warm_i;
   assign brownout_active_o = bor_live;
   assign bor_event = bor_live & brownout_trip_i;

   always_comb begin
      unique case (cfg_i.watchdog_mode_cfg)
         `RWC_MODE_ON: wdt_en = 1'b1;
         `RWC_MODE_AWAKE: wdt_en = ~sleep_i;
         `RWC_MODE_SW: wdt_en = sw_watchdog_enable_r;
         default: wdt_en = 1'b0;
      endcase
   end

   // int_osc_divider_select changes are not an input here, so the count ignores them
   assign wdt_clr = ~wdt_en | clear_watchdog_instr_i | osc_fail_i | wake_i
      | (sleep_i & ~sleep_d_r) | ost_wake_r | (state_r != RWC_ST_RUN);

   assign fault_rst = cfg_i.stack_fault_reset_enable & (stack_over_i | stack_under_i);
   assign soft_src = reset_instr_i | fault_rst | wdt_fire_r;

   // power-up sequencing: power-on/brown-out -> power-up timer -> start-up timer
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i || bor_event) begin
         state_r <= RWC_ST_POR;
         tmr_r <= '0;
      end else begin
         unique case (state_r)
            RWC_ST_POR: begin
               tmr_r <= '0;
               // modes 11/10 wait for the detector to arm; others start at once
               if (cfg_i.brownout_mode_cfg[1] == 1'b0 || brownout_ready) begin
                  state_r <= cfg_i.powerup_timer_disable_cfg ? RWC_ST_OST : RWC_ST_POWERUP_TIMER;
               end
            end
            RWC_ST_POWERUP_TIMER: begin
               if (lf_tick_i) begin
                  tmr_r <= tmr_r + 23'h000001;
               end
               if (tmr_r >= 23'(POWERUP_TIMER_TICKS)) begin
                  tmr_r <= '0;
                  state_r <= RWC_ST_OST;
               end
            end
            RWC_ST_OST: begin
               if (!cfg_i.crystal_osc || tmr_r >= 23'(OST_TICKS)) begin
                  state_r <= RWC_ST_RUN;
               end else begin
                  tmr_r <= tmr_r + 23'h000001;
               end
            end
            RWC_ST_RUN: tmr_r <= '0;
         endcase
      end
   end

   // wake with a crystal clock keeps the watchdog clear for the start-up count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ost_wake_r <= 1'b0;
         sleep_d_r <= 1'b0;
         wake_cnt_r <= '0;
      end else begin
         sleep_d_r <= sleep_i;
         // own count: the watchdog count is held at zero here, so it cannot time the hold
         if (wake_i && cfg_i.crystal_osc) begin
            ost_wake_r <= 1'b1;
            wake_cnt_r <= '0;
         end else if (ost_wake_r) begin
            if (wake_cnt_r >= 23'(OST_TICKS)) begin
               ost_wake_r <= 1'b0;
            end else begin
               wake_cnt_r <= wake_cnt_r + 23'h000001;
            end
         end
      end
   end

   // the count doubles as prescaler; cleared by every reset
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_reset_o || wdt_clr) begin
         wdt_r <= '0;
         wdt_fire_r <= 1'b0;
         watchdog_wake_o <= 1'b0;
      end else begin
         wdt_fire_r <= 1'b0;
         watchdog_wake_o <= 1'b0;
         if (lf_tick_i) begin
            if (wdt_r >= period) begin
               wdt_r <= '0;
               wdt_fire_r <= ~sleep_i;
               watchdog_wake_o <= sleep_i;
            end else begin
               wdt_r <= wdt_r + 23'h000001;
            end
         end
      end
   end

   // one synchronous reset; software sources are registered one cycle, the external pin acts at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_rst_r <= 1'b0;
         ext_d_r <= 1'b1;
      end else begin
         soft_rst_r <= soft_src;
         ext_d_r <= ext_reset_pin_n_i;
      end
   end
   assign sys_reset_o = (state_r != RWC_ST_RUN) | ~ext_reset_pin_n_i | soft_rst_r;

   // watchdog control register
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_reset_o) begin
         watchdog_period_select_r <= `RWC_WDT_RST;
         sw_watchdog_enable_r <= 1'b0;
      end else if (bus_i.wr && bus_i.addr == `RWC_ADDR_WDT) begin
         watchdog_period_select_r <= bus_i.wdata[5:1];
         sw_watchdog_enable_r <= bus_i.wdata[`RWC_BIT_SWE];
      end
   end

   // software brown-out enable survives non-power resets
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         sw_brownout_enable_r <= 1'b1;
      end else if (bus_i.wr && bus_i.addr == `RWC_ADDR_BOR) begin
         sw_brownout_enable_r <= bus_i.wdata[`RWC_BIT_SBE];
      end
   end

   // stack flags: hardware set wins over a same-cycle software clear
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         stack_over_flag_r <= 1'b0;
         stack_under_flag_r <= 1'b0;
      end else begin
         if (bus_i.wr && bus_i.addr == `RWC_ADDR_RCF) begin
            stack_over_flag_r <= bus_i.wdata[`RWC_BIT_OVF];
            stack_under_flag_r <= bus_i.wdata[`RWC_BIT_UNF];
         end
         if (stack_over_i) begin
            stack_over_flag_r <= 1'b1;
         end
         if (stack_under_i) begin
            stack_under_flag_r <= 1'b1;
         end
      end
   end

   // cause flags: hardware clear wins over a same-cycle software write
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         ext_pin_reset_flag_r <= 1'b1;
         reset_instr_flag_r <= 1'b1;
         por_flag_r <= 1'b0;
         bor_flag_r <= 1'b0;
      end else begin
         if (bus_i.wr && bus_i.addr == `RWC_ADDR_RCF) begin
            ext_pin_reset_flag_r <= bus_i.wdata[`RWC_BIT_EXT];
            reset_instr_flag_r <= bus_i.wdata[`RWC_BIT_RI];
            por_flag_r <= bus_i.wdata[`RWC_BIT_POR];
            bor_flag_r <= bus_i.wdata[`RWC_BIT_BOR];
         end
         if (ext_d_r && !ext_reset_pin_n_i) begin
            ext_pin_reset_flag_r <= 1'b0;
         end
         if (reset_instr_i) begin
            reset_instr_flag_r <= 1'b0;
         end
         if (bor_event) begin
            bor_flag_r <= 1'b0;
            ext_pin_reset_flag_r <= 1'b1;
            reset_instr_flag_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (bus_i.rd) begin
         unique case (bus_i.addr)
            `RWC_ADDR_WDT: rdata_o <= {2'h0, watchdog_period_select_r, sw_watchdog_enable_r};
            `RWC_ADDR_BOR: rdata_o <= {sw_brownout_enable_r, 6'h00, brownout_ready};
            `RWC_ADDR_RCF: rdata_o <= {stack_over_flag_r, stack_under_flag_r, 2'h0, ext_pin_reset_flag_r,
               reset_instr_flag_r, por_flag_r, bor_flag_r};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // rwc_top

// *** tb/rwc_top_sva.sv ***
// port assertions for the reset and watchdog control block
// assumes one clock domain and a bind onto rwc_top
`timescale 1ns/1ps
module rwc_top_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire rwc_pkg::rwc_cfg_t cfg_i,
   input wire rwc_pkg::rwc_bus_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic por_i,
   input wire logic ext_reset_pin_n_i,
   input wire logic sleep_i,
   input wire logic reset_instr_i,
   input wire logic stack_over_i,
   input wire logic stack_under_i,
   input wire logic sys_reset_o,
   input wire logic watchdog_wake_o,
   input wire logic brownout_active_o
);
   import rwc_pkg::*;
   logic [1:0] bm;
   assign bm = cfg_i.brownout_mode_cfg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wdt_rsvd_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 2'h0 |-> rdata_o[7:6] == 2'h0)
      else $error("watchdog reserved bits set");
   bor_rsvd_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 2'h1 |-> rdata_o[6:1] == 6'h00)
      else $error("brown-out reserved bits set");
   pin_hold_a: assert property (!ext_reset_pin_n_i |-> sys_reset_o)
      else $error("reset low while pin held");
   instr_rst_a: assert property (reset_instr_i |=> sys_reset_o)
      else $error("no reset after reset instruction");
   stack_rst_a: assert property ((stack_over_i || stack_under_i) && cfg_i.stack_fault_reset_enable |=> sys_reset_o)
      else $error("no reset after stack fault");
   por_hold_a: assert property (por_i |=> sys_reset_o)
      else $error("no reset after power-on");
   bor_on_a: assert property (bm == 2'h3 || bm == 2'h2 && !sleep_i |-> brownout_active_o)
      else $error("detector not live");
   bor_off_a: assert property (bm == 2'h0 || bm == 2'h2 && sleep_i |-> !brownout_active_o)
      else $error("detector live when off");
   wake_slp_a: assert property (watchdog_wake_o |-> $past(sleep_i) ##1 !watchdog_wake_o)
      else $error("bad watchdog wake pulse");
   rd_cov_c: cover property (bus_i.rd && bus_i.addr == 2'h2);
   wake_cov_c: cover property (watchdog_wake_o);
   run_cov_c: cover property ($fell(sys_reset_o));
endmodule // rwc_top_sva
bind rwc_top rwc_top_sva rwc_top_sva_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .por_i(por_i), .ext_reset_pin_n_i(ext_reset_pin_n_i), .sleep_i(sleep_i), .reset_instr_i(reset_instr_i),
   .stack_over_i(stack_over_i), .stack_under_i(stack_under_i), .sys_reset_o(sys_reset_o),
   .watchdog_wake_o(watchdog_wake_o), .brownout_active_o(brownout_active_o));

// *** tb/rwc_top_test.sv ***
// self-checking bench for the reset and watchdog control block
// assumes package, header and top compiled first; lf ticks every 4 clocks
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module rwc_top_test;
   import rwc_pkg::*;
   logic clk_i, rst_i, lf_tick_i, por_i, warm, pin_n, sleep_i, ri, so, su, srst, wwake, bact;
   logic trip, cw, wk;
   logic [1:0] tc;
   logic [7:0] rdata;
   rwc_cfg_t cfg;
   rwc_bus_t bus;
   int n_fail = 0;
   int samples_checked = 0;
   rwc_top #(.POWERUP_TIMER_TICKS(8), .OST_TICKS(4)) rwc_top_i (.clk_i(clk_i), .rst_i(rst_i), .lf_tick_i(lf_tick_i),
      .cfg_i(cfg), .bus_i(bus), .rdata_o(rdata), .por_i(por_i), .brownout_trip_i(trip), .brownout_warm_i(warm),
      .ext_reset_pin_n_i(pin_n), .sleep_i(sleep_i), .clear_watchdog_instr_i(cw), .osc_fail_i(1'h0),
      .wake_i(wk), .reset_instr_i(ri), .stack_over_i(so), .stack_under_i(su), .sys_reset_o(srst),
      .watchdog_wake_o(wwake), .brownout_active_o(bact));
   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end
   // a fast tick keeps watchdog periods short; the design only counts pulses
   always @(posedge clk_i) begin
      tc <= tc + 2'h1;
      lf_tick_i <= (tc == 2'h3);
   end
   task automatic close_out();
      if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
      @(posedge clk_i);
      bus.wr <= 1'h0;
   endtask
   task automatic rchk(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
      @(posedge clk_i);
      bus.rd <= 1'h0;
      #1 `CHK(rdata, e)
   endtask
   // m[1] picks wake or reset, m[0] the level looked for; e says whether it must show
   task automatic wchk(input logic [1:0] m, input int n, input logic e);
      logic ok;
      ok = 1'h0;
      for (int i = 0; i < n && !ok; i++) begin
         @(posedge clk_i);
         #1 ok = ((m[1] ? wwake : srst) === m[0]);
      end
      `CHK(ok, e)
      if (e && !ok) close_out();
   endtask
   task automatic pls(input int k);
      @(posedge clk_i);
      {ri, so, su} <= 3'(1 << k);
      @(posedge clk_i);
      {ri, so, su} <= 3'h0;
   endtask
   task automatic t_flags();
      pls(1);
      wchk(2'h1, 4, 1'h0);
      rchk(2'h2, 8'h8c);
      wr(2'h2, 8'h0c);
      rchk(2'h2, 8'h0c);
      pls(2);
      wchk(2'h0, 20, 1'h1);
      rchk(2'h2, 8'h08);
      wr(2'h2, 8'h0e);
      rchk(2'h2, 8'h0e);
      @(posedge clk_i);
      pin_n <= 1'h0;
      cyc(3);
      pin_n <= 1'h1;
      wchk(2'h0, 20, 1'h1);
      rchk(2'h2, 8'h06);
      cfg.stack_fault_reset_enable <= 1'h1;
      pls(0);
      wchk(2'h0, 20, 1'h1);
      rchk(2'h2, 8'h46);
   endtask
   task automatic t_wdt();
      logic [7:0] codes [2] = '{8'h01, 8'h27};
      foreach (codes[k]) begin
         wr(2'h0, codes[k]);
         wchk(2'h1, 112, 1'h0);
         wchk(2'h1, 30, 1'h1);
         wchk(2'h0, 20, 1'h1);
         rchk(2'h0, 8'h16);
      end
      cfg.watchdog_mode_cfg <= 2'h0;
      wr(2'h0, 8'h01);
      wchk(2'h1, 200, 1'h0);
      sleep_i <= 1'h1;
      cfg.watchdog_mode_cfg <= 2'h2;
      wchk(2'h3, 200, 1'h0);
      cfg.watchdog_mode_cfg <= 2'h3;
      wchk(2'h3, 150, 1'h1);
      `CHK(srst, 1'h0)
      sleep_i <= 1'h0;
      cfg.watchdog_mode_cfg <= 2'h0;
   endtask
   task automatic t_bor();
      logic [3:0] tab [5] = '{4'hd, 4'h9, 4'ha, 4'h5, 4'h0};
      foreach (tab[k]) begin
         @(posedge clk_i);
         cfg.brownout_mode_cfg <= tab[k][3:2];
         sleep_i <= tab[k][1];
         @(posedge clk_i);
         #1 `CHK(bact, tab[k][0])
      end
      cfg.brownout_mode_cfg <= 2'h3;
      warm <= 1'h1;
      rchk(2'h1, 8'h80);
      warm <= 1'h0;
      rchk(2'h1, 8'h81);
      cfg.brownout_mode_cfg <= 2'h1;
      // the ready bit is read-only, so writing it must not stick
      wr(2'h1, 8'h01);
      rchk(2'h1, 8'h00);
      `CHK(bact, 1'h0)
      cfg.brownout_mode_cfg <= 2'h0;
      wr(2'h1, 8'h80);
      rchk(2'h1, 8'h80);
   endtask
   task automatic t_pin();
      @(posedge clk_i);
      por_i <= 1'h1;
      pin_n <= 1'h0;
      @(posedge clk_i);
      por_i <= 1'h0;
      wchk(2'h0, 80, 1'h0);
      pin_n <= 1'h1;
      wchk(2'h0, 3, 1'h1);
   endtask
   // clear instruction, crystal wake hold and a brown-out held from run state
   task automatic t_clr();
      cfg.watchdog_mode_cfg <= 2'h1;
      wr(2'h0, 8'h01);
      repeat (3) begin
         wchk(2'h1, 90, 1'h0);
         cw <= 1'h1;
         @(posedge clk_i);
         cw <= 1'h0;
      end
      wchk(2'h1, 140, 1'h1);
      wr(2'h0, 8'h01);
      wk <= 1'h1;
      @(posedge clk_i);
      wk <= 1'h0;
      wchk(2'h1, 150, 1'h1);
      cfg.watchdog_mode_cfg <= 2'h0;
      cfg.brownout_mode_cfg <= 2'h3;
      trip <= 1'h1;
      wchk(2'h1, 3, 1'h1);
      cyc(60);
      `CHK(srst, 1'h1)
      trip <= 1'h0;
      wchk(2'h0, 60, 1'h1);
      cfg.brownout_mode_cfg <= 2'h0;
   endtask
   initial begin
      {rst_i, por_i, pin_n, sleep_i, warm, ri, so, su, lf_tick_i} = 9'h1c0;
      tc = 2'h0;
      {trip, cw, wk} = 3'h0;
      cfg = '{2'h1, 2'h0, 1'h0, 1'h0, 1'h1};
      bus = '0;
      cyc(2);
      rst_i <= 1'h0;
      cyc(2);
      por_i <= 1'h0;
      wchk(2'h0, 24, 1'h0);
      wchk(2'h0, 40, 1'h1);
      rchk(2'h2, 8'h0c);
      rchk(2'h0, 8'h16);
      rchk(2'h1, 8'h80);
      rchk(2'h3, 8'h00);
      t_flags();
      t_wdt();
      t_bor();
      t_pin();
      t_clr();
      close_out();
   end
endmodule // rwc_top_test
